// ===== src/sarcr_pkg.sv
// Purpose: Constants for the secondary converter control block
// Assumes: Byte-wide register port, 100 MHz system clock
// Notes: Register indices chosen locally
package sarcr_pkg;
    localparam logic [0:0] ADDR_CONFIG = 1'h0;
    localparam logic [0:0] ADDR_CONTROL = 1'h1;
    localparam logic [7:0] CONFIG_RESET = 8'hf8;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_TRACK = 6;
    localparam int BIT_DONE = 5;
    localparam int BIT_BUSY = 4;
    localparam int BIT_MODE_HI = 3;
    localparam int BIT_MODE_LO = 1;
    localparam int BIT_WINDOW = 0;
    localparam int DIV_HI = 7;
    localparam int DIV_LO = 3;
    localparam int GAIN_HI = 1;
    localparam int GAIN_LO = 0;
    localparam logic [7:0] CONFIG_WMASK = 8'hfb;
    localparam logic [3:0] TRACK_CLOCKS = 4'h3;
    localparam logic [3:0] CONVERT_CLOCKS = 4'h8;
    localparam logic [2:0] MODE_SOFT = 3'h0;
    localparam logic [2:0] MODE_TIMER = 3'h1;
    localparam logic [2:0] MODE_PIN = 3'h2;
    localparam logic [2:0] MODE_TIMER2 = 3'h3;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_IDLE = 4'h2,
        ST_TRACK = 4'h4,
        ST_CONV = 4'h8
    } sarcr_state_t;
endpackage : sarcr_pkg

// ===== src/sarcr_divider.sv
// Purpose: Conversion clock enable divider
// Assumes: Divide ratio is field value plus one
// Notes: One-cycle pulse output
`timescale 1ns/1ps
module sarcr_divider (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [4:0] div,
    output logic tick
);
    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } sarcr_div_t;
    sarcr_div_t q, next_q;
    always_comb begin
        next_q = q;
        next_q.tick = 1'b0;
        if (!run) begin
            next_q.cnt = 5'h00;
        end else if (q.cnt >= div) begin
            next_q.cnt = 5'h00;
            next_q.tick = 1'b1;
        end else begin
            next_q.cnt = q.cnt + 5'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign tick = q.tick;
endmodule : sarcr_divider

// ===== src/sarcr_top.sv
// Purpose: Control and configuration registers of the secondary 8-bit converter
// Assumes: Conversion datapath sits outside and reports the window compare event
// Notes: Conversion length is a fixed count of conversion clocks
// Behaviour
// - Enable bit low keeps the converter shut down with no conversions.
// - Enable bit high keeps the converter active and ready to convert.
// - Track mode 1 tracks only in windows chosen by the start mode field.
// - Done flag reads 1 after a conversion finished or a write of 1, 0 if neither since the clear.
// - Busy reads 0 whenever no conversion runs.
// - Gain field bits 1-0 select gain 0.5, 1, 2, 4.
// - Control bits: enable 7, track 6, done 5, busy 4, mode 3-1, window 0.
// - Done flag sets on the falling edge of busy at the end of a conversion, not when shutdown aborts one.
// - Writing 1 to busy starts a conversion only in start mode 000.
// - Start modes 1xx start on a write of 1 to the primary converter busy bit.
// - In low-power track mode a start tracks 3 conversion clocks, then converts.
`timescale 1ns/1ps
module sarcr_top (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [0:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic PRIMARY_START,
    input wire logic TIMER_OVF,
    input wire logic CONV_PIN,
    input wire logic WINDOW_HIT,
    output logic POWER_ON,
    output logic TRACKING,
    output logic CONVERTING,
    output logic [1:0] GAIN_SEL,
    output logic SAR_TICK
);
    typedef struct packed {
        logic [7:0] cfg;
        logic enable;
        logic track;
        logic done;
        logic busy;
        logic [2:0] mode;
        logic window;
        sarcr_pkg::sarcr_state_t state;
        logic [3:0] cnt;
        logic [7:0] rdata;
        logic [1:0] pin_sync;
        logic pin_prev;
        logic power_on;
        logic tracking;
        logic tick;
    } sarcr_regs_t;
    sarcr_regs_t q, next_q;
    logic tick;
    logic start;
    logic pin_rise;
    logic [7:0] control_view;
    logic is_ctl_wr;

    ////////////////////////////////////////////////////////////////////////
    sarcr_divider u_div (
        .clk(MCLK),
        .rst_n(RESETN),
        .run(q.enable),
        .div(q.cfg[sarcr_pkg::DIV_HI:sarcr_pkg::DIV_LO]),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        control_view = {q.enable, q.track, q.done, q.busy, q.mode, q.window};
        is_ctl_wr = WR && ADDR == sarcr_pkg::ADDR_CONTROL;
        pin_rise = q.pin_sync[1] && !q.pin_prev;
        // Trigger sources decoded from the start mode field
        start = 1'b0;
        if (q.mode[2]) begin
            start = PRIMARY_START;
        end else begin
            case (q.mode)
                sarcr_pkg::MODE_SOFT: start = is_ctl_wr && WDATA[sarcr_pkg::BIT_BUSY];
                sarcr_pkg::MODE_TIMER: start = TIMER_OVF;
                sarcr_pkg::MODE_PIN: start = pin_rise;
                sarcr_pkg::MODE_TIMER2: start = TIMER_OVF;
                default: start = 1'b0;
            endcase
        end
    end

    always_comb begin
        next_q = q;
        next_q.pin_sync = {q.pin_sync[0], CONV_PIN};
        next_q.pin_prev = q.pin_sync[1];
        next_q.tick = tick;
        if (WR && ADDR == sarcr_pkg::ADDR_CONFIG) begin
            next_q.cfg = WDATA & sarcr_pkg::CONFIG_WMASK;
        end
        if (is_ctl_wr) begin
            next_q.enable = WDATA[sarcr_pkg::BIT_ENABLE];
            next_q.track = WDATA[sarcr_pkg::BIT_TRACK];
            // Only a write of 0 can clear; writing 1 is kept as a manual set
            next_q.done = WDATA[sarcr_pkg::BIT_DONE];
            next_q.mode = WDATA[sarcr_pkg::BIT_MODE_HI:sarcr_pkg::BIT_MODE_LO];
            next_q.window = WDATA[sarcr_pkg::BIT_WINDOW];
        end
        if (WINDOW_HIT && q.busy) begin
            next_q.window = 1'b1;
        end
        case (q.state)
            sarcr_pkg::ST_OFF: begin
                if (q.enable) begin
                    next_q.state = sarcr_pkg::ST_IDLE;
                end
            end
            sarcr_pkg::ST_IDLE: begin
                if (start) begin
                    next_q.busy = 1'b1;
                    next_q.cnt = 4'h0;
                    // Low-power mode tracks first; normal mode is already tracking
                    next_q.state = q.track ? sarcr_pkg::ST_TRACK : sarcr_pkg::ST_CONV;
                end
            end
            sarcr_pkg::ST_TRACK: begin
                if (tick) begin
                    next_q.cnt = q.cnt + 4'h1;
                    if (q.cnt + 4'h1 == sarcr_pkg::TRACK_CLOCKS) begin
                        next_q.cnt = 4'h0;
                        next_q.state = sarcr_pkg::ST_CONV;
                    end
                end
            end
            sarcr_pkg::ST_CONV: begin
                if (tick) begin
                    next_q.cnt = q.cnt + 4'h1;
                    if (q.cnt + 4'h1 == sarcr_pkg::CONVERT_CLOCKS) begin
                        next_q.cnt = 4'h0;
                        next_q.busy = 1'b0;
                        next_q.done = 1'b1;
                        next_q.state = sarcr_pkg::ST_IDLE;
                    end
                end
            end
            default: next_q.state = sarcr_pkg::ST_OFF;
        endcase
        if (!q.enable) begin
            // Shutdown aborts any conversion in flight
            next_q.state = sarcr_pkg::ST_OFF;
            next_q.busy = 1'b0;
            next_q.cnt = 4'h0;
        end
        next_q.power_on = next_q.state != sarcr_pkg::ST_OFF;
        if (next_q.state == sarcr_pkg::ST_TRACK) begin
            next_q.tracking = 1'b1;
        end else if (next_q.state == sarcr_pkg::ST_IDLE) begin
            // Pin mode low-power tracking runs while the synchronised pin level is low
            next_q.tracking = !next_q.track ||
                (next_q.mode == sarcr_pkg::MODE_PIN && !q.pin_sync[1]);
        end else begin
            next_q.tracking = 1'b0;
        end
        next_q.rdata = 8'h00;
        if (RD) begin
            next_q.rdata = (ADDR == sarcr_pkg::ADDR_CONTROL) ? control_view : q.cfg;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= '0;
            q.cfg <= sarcr_pkg::CONFIG_RESET;
            q.state <= sarcr_pkg::ST_OFF;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign RDATA = q.rdata;
    assign POWER_ON = q.power_on;
    assign TRACKING = q.tracking;
    assign CONVERTING = q.busy;
    assign GAIN_SEL = q.cfg[sarcr_pkg::GAIN_HI:sarcr_pkg::GAIN_LO];
    assign SAR_TICK = q.tick;

    ////////////////////////////////////////////////////////////////////////
    off_no_busy_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        !q.enable |=> !q.busy && !q.power_on)
        else $error("busy while disabled");
    on_power_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        q.enable && $past(q.enable) |=> q.power_on)
        else $error("enabled but powered down");
    normal_track_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        q.state == sarcr_pkg::ST_IDLE && !q.track && $stable(q.track) && q.enable && !start && !is_ctl_wr
        |=> q.tracking)
        else $error("normal mode not tracking");
    soft_start_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        q.state == sarcr_pkg::ST_IDLE && q.enable && is_ctl_wr && WDATA[sarcr_pkg::BIT_BUSY]
        && WDATA[sarcr_pkg::BIT_ENABLE] && q.mode == sarcr_pkg::MODE_SOFT |=> q.busy)
        else $error("soft start missed");
    no_soft_start_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        q.state == sarcr_pkg::ST_IDLE && is_ctl_wr && q.mode != sarcr_pkg::MODE_SOFT && q.mode[2] == 1'b0
        && !TIMER_OVF && !pin_rise |=> !q.busy)
        else $error("start in wrong mode");
    done_on_fall_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        $fell(q.busy) && q.enable && $past(q.enable) |-> q.done)
        else $error("done not set on busy fall");
    done_sticky_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        q.done && !is_ctl_wr |=> q.done)
        else $error("done cleared by hardware");
    track_three_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        q.state == sarcr_pkg::ST_TRACK && q.cnt == 4'h2 && tick && q.enable
        |=> q.state == sarcr_pkg::ST_CONV)
        else $error("track length wrong");
    primary_start_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        q.state == sarcr_pkg::ST_IDLE && q.enable && q.mode[2] && PRIMARY_START
        |=> q.busy)
        else $error("primary start missed");
endmodule : sarcr_top

// ===== dv/sar_adc_control_regs_tb_top.sv
// Purpose: Self-checking bench for the secondary converter control registers
// Assumes: Byte register port, one 100 MHz clock, bench drives every input
// Notes: Divider set to 1 for conversions to keep runs short
`timescale 1ns/1ps
module sar_adc_control_regs_tb_top;
    logic MCLK, RESETN, ADDR, WR, RD, PRIMARY_START, TIMER_OVF, CONV_PIN, WINDOW_HIT;
    logic [7:0] WDATA, RDATA, tk, ck, n, cv;
    logic POWER_ON, TRACKING, CONVERTING, SAR_TICK, both;
    logic [1:0] GAIN_SEL;
    int fail_count, n_tests;

    sarcr_top dut (.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .PRIMARY_START(PRIMARY_START), .TIMER_OVF(TIMER_OVF), .CONV_PIN(CONV_PIN),
        .WINDOW_HIT(WINDOW_HIT), .POWER_ON(POWER_ON), .TRACKING(TRACKING), .CONVERTING(CONVERTING),
        .GAIN_SEL(GAIN_SEL), .SAR_TICK(SAR_TICK));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic a, input logic [7:0] exp);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        @(negedge MCLK);
        chk(RDATA, exp);
    endtask : rd

    // Select high pulses the primary start, low the timer overflow
    task automatic pulse(input logic sel);
        @(posedge MCLK);
        if (sel) PRIMARY_START <= 1'b1;
        else TIMER_OVF <= 1'b1;
        @(posedge MCLK);
        PRIMARY_START <= 1'b0;
        TIMER_OVF <= 1'b0;
    endtask : pulse

    // SAR_TICK lags the internal tick by a cycle, so count against the previous phase
    task automatic conv();
        logic seen, prev_conv, prev_trk;
        seen = 1'b0;
        prev_conv = 1'b0;
        prev_trk = 1'b0;
        tk = 8'h00;
        ck = 8'h00;
        both = 1'b0;
        repeat (400) begin
            @(negedge MCLK);
            if (prev_trk && SAR_TICK === 1'b1) tk++;
            if (prev_conv && SAR_TICK === 1'b1) ck++;
            prev_trk = CONVERTING === 1'b1 && TRACKING === 1'b1;
            prev_conv = CONVERTING === 1'b1 && TRACKING !== 1'b1;
            if (CONVERTING === 1'b1) begin
                seen = 1'b1;
                if (TRACKING !== 1'b0) both = 1'b1;
            end else if (seen) break;
        end
    endtask : conv

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        {RESETN, ADDR, WDATA, WR, RD, PRIMARY_START, TIMER_OVF, CONV_PIN, WINDOW_HIT} = '0;
        fail_count = 0;
        n_tests = 0;
        repeat (16) @(posedge MCLK);
        RESETN <= 1'b1;
        rd(1'b1, sarcr_pkg::CONTROL_RESET);
        rd(1'b0, sarcr_pkg::CONFIG_RESET);
        chk(POWER_ON, 8'h00);
        wr(1'b0, 8'hff);
        rd(1'b0, sarcr_pkg::CONFIG_WMASK);
        for (int g = 0; g < 4; g++) begin
            wr(1'b0, {6'h02, g[1:0]});
            @(negedge MCLK);
            chk(GAIN_SEL, g[7:0]);
        end
        wr(1'b1, 8'h80);
        repeat (2) @(negedge MCLK);
        chk(POWER_ON, 8'h01);
        chk(TRACKING, 8'h01);
        for (int d = 0; d < 5; d += 2) begin
            wr(1'b0, {d[4:0], 3'h0});
            repeat (8) @(negedge MCLK);
            n = 8'h00;
            repeat (60) begin
                @(negedge MCLK);
                if (SAR_TICK === 1'b1) n++;
            end
            chk(n, 8'(60 / (d + 1)));
        end
        wr(1'b0, 8'h08);
        // Every start source, each refusing a busy write unless mode 000
        for (int m = 0; m < 5; m++) begin
            cv = {4'h8, m[2:0], 1'b0};
            // Mode must be in place before the busy write is judged
            wr(1'b1, cv);
            wr(1'b1, cv | 8'h10);
            if (m != 0) begin
                repeat (10) @(negedge MCLK);
                chk(CONVERTING, 8'h00);
                @(posedge MCLK);
            end
            WINDOW_HIT <= (m == 4);
            if (m == 1 || m == 3) pulse(1'b0);
            if (m == 2) CONV_PIN <= 1'b1;
            if (m == 4) pulse(1'b1);
            conv();
            chk(ck, {4'h0, sarcr_pkg::CONVERT_CLOCKS});
            chk(both, 8'h00);
            rd(1'b1, cv | 8'h20 | {7'h00, m == 4});
            @(posedge MCLK);
            CONV_PIN <= 1'b0;
            WINDOW_HIT <= 1'b0;
            wr(1'b1, cv);
            rd(1'b1, cv);
        end
        wr(1'b1, 8'hc0);
        repeat (4) @(negedge MCLK);
        chk(TRACKING, 8'h00);
        wr(1'b1, 8'hd0);
        conv();
        chk(tk, {4'h0, sarcr_pkg::TRACK_CLOCKS});
        chk(ck, {4'h0, sarcr_pkg::CONVERT_CLOCKS});
        wr(1'b1, 8'h80);
        repeat (2) @(posedge MCLK);
        wr(1'b1, 8'h90);
        repeat (4) @(negedge MCLK);
        chk(CONVERTING, 8'h01);
        // Disable in mid-conversion must abort without a done flag
        wr(1'b1, 8'h00);
        repeat (2) @(negedge MCLK);
        chk({POWER_ON, CONVERTING}, 8'h00);
        rd(1'b1, 8'h00);
        tally_and_finish();
    end
endmodule : sar_adc_control_regs_tb_top
